/* src/flash_host_pkg.sv */
// constants for the parallel flash status host controller
package flash_host_pkg;
	// apb register offsets
	localparam logic [7:0] ADDR_OFS = 8'h00;
	localparam logic [7:0] WDATA_OFS = 8'h04;
	localparam logic [7:0] GO_OFS = 8'h08;
	localparam logic [7:0] RDATA_OFS = 8'h0C;
	localparam logic [7:0] STAT_OFS = 8'h10;
	localparam logic [7:0] CTRL_OFS = 8'h14;
	// go register fields
	localparam int GO_WRITE_BIT = 0;
	localparam int GO_READ_BIT = 1;
	localparam int GO_RESET_BIT = 2;
	// ctrl register fields
	localparam int CTRL_AUTOCLR_BIT = 0;
	localparam logic CTRL_AUTOCLR_RST = 1'b0;
	// status byte fields
	localparam int READY_BIT = 7;
	localparam int ERASE_SUSP_BIT = 6;
	localparam int ERASE_ERR_BIT = 5;
	localparam int PROG_ERR_BIT = 4;
	localparam int SUPPLY_LOW_BIT = 3;
	localparam int PROG_SUSP_BIT = 2;
	localparam int LOCKED_BIT = 1;
	localparam logic [7:0] RESERVED_MASK = 8'hFE;
	localparam logic [7:0] SEQ_ERR_MASK = 8'h3A;
	localparam logic [7:0] STAT_RST = 8'h00;
	// timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int STROBE_NS = 100;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_NS = 500;
	localparam int RESET_CYC = (RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_STAGES = 2;
	localparam logic [15:0] DATA_RST = 16'h0000;
endpackage

/* src/pin_sync.sv */
// two-stage synchroniser for the flash data inputs
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 16
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	if (WIDTH < 1) begin : g_bad_width
		$error("pin_sync: width must be at least one");
	end

	// ==========================================
	// per-bit flop pair
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_ff;
			logic sync_ff;
			always_ff @(posedge core_clk or posedge sys_rst) begin
				if (sys_rst) begin
					meta_ff <= 1'b0;
					sync_ff <= 1'b0;
				end else if (clk_en) begin
					meta_ff <= async_in[i];
					sync_ff <= meta_ff;
				end
			end
			assign sync_out[i] = sync_ff;
		end
	endgenerate
endmodule

/* src/flash_status_host.sv */
// host controller driving flash pins, with apb registers for software
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module flash_status_host
	import flash_host_pkg::*;
#(
	parameter int STROBE_CYCLES = STROBE_CYC,
	parameter int RESET_CYCLES = RESET_CYC,
	parameter logic [7:0] STATUS_READ_CMD = 8'h70,
	parameter logic [7:0] STATUS_CLEAR_CMD = 8'h50,
	parameter logic [7:0] ARRAY_READ_CMD = 8'hFF,
	parameter logic [7:0] PROGRAM_CMD = 8'h40,
	parameter logic [7:0] ERASE_CMD = 8'h20
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic flash_rst_n,
	output logic [20:0] flash_addr,
	output logic [15:0] dq_out,
	output logic dq_oe,
	input wire logic [15:0] dq_in
);
	// ==========================================
	// parameter checks
	if (STROBE_CYCLES < 1 || STROBE_CYCLES > 200 || RESET_CYCLES < 1 || RESET_CYCLES > 60000) begin : g_bad_timing
		$error("flash_status_host: timing parameter out of range");
	end

	localparam logic [15:0] STROBE_LEN = 16'(STROBE_CYCLES);
	localparam logic [15:0] READ_LEN = 16'(STROBE_CYCLES + SYNC_STAGES);
	localparam logic [15:0] RESET_LEN = 16'(RESET_CYCLES);

	typedef enum logic [2:0] {IDLE, W_SETUP, W_PULSE, W_HOLD, R_PULSE, GAP, RST_PULSE} fsm_e;

	typedef struct packed {
		fsm_e fsm;
		logic [15:0] cnt;
		logic [20:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [7:0] stat;
		logic status_mode;
		logic upper_nz;
		logic auto_clr;
		logic pend;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic rst_n;
		logic dq_oe;
		logic [15:0] dq_out;
		logic [20:0] addr_out;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} state_s;

	state_s st_ff;
	state_s nxt_st;
	logic [15:0] dq_sync;
	logic busy;
	logic acc;
	logic is_status_read;

	// ==========================================
	// data input synchroniser
	pin_sync #(.WIDTH(16)) u_sync (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.async_in(dq_in),
		.sync_out(dq_sync)
	);

	assign busy = (st_ff.fsm != IDLE) || st_ff.pend;
	assign acc = psel && penable && !st_ff.pready;

	// ==========================================
	// next state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.pready = acc;
		nxt_st.pslverr = 1'b0;
		is_status_read = 1'b0;
		// apb access, taken one cycle into the access phase
		if (acc) begin
			nxt_st.prdata = 32'h0000_0000;
			case (paddr)
				ADDR_OFS: begin
					nxt_st.prdata = {11'h000, st_ff.addr};
					if (pwrite && !busy) begin
						nxt_st.addr = pwdata[20:0];
					end
				end
				WDATA_OFS: begin
					nxt_st.prdata = {16'h0000, st_ff.wdata};
					if (pwrite && !busy) begin
						nxt_st.wdata = pwdata[15:0];
					end
				end
				GO_OFS: begin
					nxt_st.prdata = {31'h0000_0000, busy};
					if (pwrite) begin
						if (busy) begin
							nxt_st.pslverr = 1'b1;
						end else if (pwdata[GO_RESET_BIT]) begin
							nxt_st.fsm = RST_PULSE;
							nxt_st.cnt = RESET_LEN;
							nxt_st.rst_n = 1'b0;
						end else if (pwdata[GO_WRITE_BIT]) begin
							// optional status clear ahead of program or erase
							if (st_ff.auto_clr && (st_ff.wdata[7:0] == PROGRAM_CMD || st_ff.wdata[7:0] == ERASE_CMD)) begin
								nxt_st.pend = 1'b1;
							end
							nxt_st.fsm = W_SETUP;
						end else if (pwdata[GO_READ_BIT]) begin
							nxt_st.fsm = R_PULSE;
							nxt_st.cnt = READ_LEN;
							nxt_st.ce_n = 1'b0;
							nxt_st.oe_n = 1'b0;
							nxt_st.addr_out = st_ff.addr;
						end
					end
				end
				RDATA_OFS: nxt_st.prdata = {16'h0000, st_ff.rdata};
				STAT_OFS: begin
					nxt_st.prdata = {16'h0000, st_ff.stat & RESERVED_MASK, 4'h0,
						((st_ff.stat & SEQ_ERR_MASK) == SEQ_ERR_MASK), st_ff.upper_nz, st_ff.status_mode, busy};
				end
				CTRL_OFS: begin
					nxt_st.prdata = {31'h0000_0000, st_ff.auto_clr};
					if (pwrite) begin
						nxt_st.auto_clr = pwdata[CTRL_AUTOCLR_BIT];
					end
				end
				default: nxt_st.pslverr = 1'b1;
			endcase
		end
		// flash bus sequencer
		case (st_ff.fsm)
			IDLE: ;
			W_SETUP: begin
				// select low, drive high, data and address driven
				nxt_st.fsm = W_PULSE;
				nxt_st.cnt = STROBE_LEN;
				nxt_st.ce_n = 1'b0;
				nxt_st.oe_n = 1'b1;
				nxt_st.dq_oe = 1'b1;
				nxt_st.addr_out = st_ff.addr;
				nxt_st.dq_out = st_ff.pend ? {8'h00, STATUS_CLEAR_CMD} : st_ff.wdata;
			end
			W_PULSE: begin
				nxt_st.we_n = 1'b0;
				nxt_st.cnt = st_ff.cnt - 16'h0001;
				if (st_ff.cnt == 16'h0001) begin
					nxt_st.fsm = W_HOLD;
				end
			end
			W_HOLD: begin
				// rising write strobe latches, select released a cycle later
				nxt_st.we_n = 1'b1;
				nxt_st.fsm = GAP;
				nxt_st.status_mode = (st_ff.dq_out[7:0] == STATUS_READ_CMD);
			end
			R_PULSE: begin
				nxt_st.cnt = st_ff.cnt - 16'h0001;
				if (st_ff.cnt == 16'h0001) begin
					nxt_st.fsm = GAP;
					nxt_st.rdata = dq_sync;
					is_status_read = st_ff.status_mode;
				end
			end
			GAP: begin
				// select and drive both high for a cycle before any next access
				nxt_st.ce_n = 1'b1;
				nxt_st.oe_n = 1'b1;
				nxt_st.dq_oe = 1'b0;
				if (st_ff.ce_n) begin
					if (st_ff.pend) begin
						nxt_st.pend = 1'b0;
						nxt_st.fsm = W_SETUP;
					end else begin
						nxt_st.fsm = IDLE;
					end
				end
			end
			RST_PULSE: begin
				nxt_st.cnt = st_ff.cnt - 16'h0001;
				if (st_ff.cnt == 16'h0001) begin
					nxt_st.rst_n = 1'b1;
					nxt_st.fsm = IDLE;
					nxt_st.status_mode = 1'b0;
					nxt_st.stat = STAT_RST;
				end
			end
			default: nxt_st.fsm = IDLE;
		endcase
		if (is_status_read) begin
			nxt_st.stat = dq_sync[7:0];
			nxt_st.upper_nz = (dq_sync[15:8] != 8'h00);
		end
	end

	// ==========================================
	// state register
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= '{fsm: IDLE, cnt: 16'h0000, addr: 21'h00_0000, wdata: DATA_RST, rdata: DATA_RST,
				stat: STAT_RST, status_mode: 1'b0, upper_nz: 1'b0, auto_clr: CTRL_AUTOCLR_RST, pend: 1'b0,
				ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1, dq_oe: 1'b0, dq_out: DATA_RST,
				addr_out: 21'h00_0000, pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};
		end else if (clk_en) begin
			st_ff <= nxt_st;
		end
	end

	assign prdata = st_ff.prdata;
	assign pready = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign flash_ce_n = st_ff.ce_n;
	assign flash_oe_n = st_ff.oe_n;
	assign flash_we_n = st_ff.we_n;
	assign flash_rst_n = st_ff.rst_n;
	assign flash_addr = st_ff.addr_out;
	assign dq_out = st_ff.dq_out;
	assign dq_oe = st_ff.dq_oe;

	// ==========================================
	// assertions
	write_drive_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		!flash_we_n |-> (!flash_ce_n && flash_oe_n && dq_oe))
		else $error("write strobe low without select, drive high and data");
	we_data_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(clk_en && $rose(flash_we_n)) |-> ($stable(dq_out) && $stable(flash_addr) && !flash_ce_n))
		else $error("data or address moved on write strobe release");
	read_toggle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(clk_en && $rose(flash_oe_n)) |=> flash_ce_n || !clk_en)
		else $error("select not toggled after a read");
	read_gap_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(clk_en && st_ff.fsm == GAP && st_ff.ce_n) |-> (flash_oe_n && flash_we_n))
		else $error("strobes not all high in gap");
	mode_track_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(clk_en && st_ff.fsm == W_HOLD && st_ff.dq_out[7:0] == ARRAY_READ_CMD) |=> !st_ff.status_mode)
		else $error("status mode kept after array read command");
	mask_bit_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(pready && $past(paddr) == STAT_OFS && $past(psel)) |-> !prdata[8])
		else $error("reserved status bit not masked");
	preclear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(clk_en && st_ff.fsm == W_SETUP && st_ff.pend) |=> (dq_out[7:0] == STATUS_CLEAR_CMD))
		else $error("status clear not issued first");

	cov_write_c: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(flash_we_n));
	cov_status_c: cover property (@(posedge core_clk) disable iff (sys_rst) is_status_read && clk_en);
	cov_preclear_c: cover property (@(posedge core_clk) disable iff (sys_rst) st_ff.pend && st_ff.fsm == GAP);
	cov_reset_c: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(flash_rst_n));
endmodule

/* test/flash_dev_model.sv */
// behavioural flash device answering the host controller pins
`timescale 1ns/1ps
module flash_dev_model #(
	parameter int BUSY_NS = 4000
) (
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic rst_n,
	input wire logic [20:0] addr,
	input wire logic [15:0] dq,
	input wire logic [7:0] fault,
	output logic [15:0] dq_drv,
	output logic drv_en
);
	// reserved bit 0 reads one so host masking shows
	// suspend bits 2 and 6 stay clear, no suspend here
	logic [7:0] stat = 8'h81;
	logic [7:0] snap = 8'h81;
	logic stat_mode = 1'h0;
	logic pend = 1'h0;
	event go;
	// ====================
	// command capture
	always @(posedge we_n) begin
		if (!ce_n && oe_n && rst_n) begin
			if (pend) begin
				pend = 1'h0;
				->go;
			end else begin
				stat_mode = (dq[7:0] == 8'h70);
				pend = (dq[7:0] == 8'h40) || (dq[7:0] == 8'h20);
				if (dq[7:0] == 8'h50)
					stat = stat & 8'hC5;
			end
		end
	end
	always @(go) begin
		stat[7] = 1'h0;
		#(BUSY_NS);
		stat = stat | fault | 8'h80;
	end
	always @(negedge rst_n) begin
		stat = 8'h81;
		stat_mode = 1'h0;
		pend = 1'h0;
	end
	always @(negedge ce_n or negedge oe_n)
		if (!ce_n && !oe_n)
			snap = stat;
	assign drv_en = !ce_n && !oe_n && rst_n;
	always @*
		if (drv_en)
			dq_drv = stat_mode ? {8'h00, snap} : (addr[15:0] ^ 16'hA5C3);
	// released bus shows the inverse of the last value
	always @(negedge drv_en)
		dq_drv = ~dq_drv;
endmodule

/* test/flash_status_host_tb.sv */
// self-checking bench for the flash status host controller
`timescale 1ns/1ps
module flash_status_host_tb;
	import flash_host_pkg::*;
	logic core_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic clk_en = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, ce_n, oe_n, we_n, rst_n, dq_oe, drv_en, err;
	logic [20:0] faddr;
	logic [15:0] dq_out, dq_drv, dq_wire;
	logic [7:0] fault = 8'h00;
	int fails = 0;
	int checked = 0;
	int cycles = 0;
	always #12.5 core_clk = ~core_clk;
	assign dq_wire = dq_oe ? dq_out : dq_drv;
	flash_status_host DUT (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
		.flash_rst_n(rst_n), .flash_addr(faddr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_wire));
	flash_dev_model MODEL (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rst_n(rst_n), .addr(faddr),
		.dq(dq_wire), .fault(fault), .dq_drv(dq_drv), .drv_en(drv_en));
	// ====================
	// tasks
	task automatic report_and_stop();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		do @(posedge core_clk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge core_clk);
	endtask
	task automatic idle();
		int n;
		n = 0;
		do begin
			apb(1'h0, GO_OFS, 32'h0);
			n++;
		end while (rd[0] !== 1'h0 && n < 100);
		check({31'h0, rd[0]}, 32'h0);
	endtask
	task automatic cmd(input logic [20:0] a, input logic [15:0] d);
		apb(1'h1, ADDR_OFS, {11'h0, a});
		apb(1'h1, WDATA_OFS, {16'h0, d});
		apb(1'h1, GO_OFS, 32'h1);
		idle();
	endtask
	task automatic fread(input logic [20:0] a);
		apb(1'h1, ADDR_OFS, {11'h0, a});
		apb(1'h1, GO_OFS, 32'h2);
		idle();
		apb(1'h0, RDATA_OFS, 32'h0);
	endtask
	task automatic run_op(input logic [15:0] op, input logic [7:0] f);
		int n;
		fault <= f;
		cmd(21'h0, op);
		cmd(21'h40, 16'h00D0);
		cmd(21'h0, 16'h0070);
		fread(21'h0);
		check({31'h0, rd[7]}, 32'h0);
		n = 0;
		while (rd[7] !== 1'h1 && n < 40) begin
			fread(21'h0);
			n++;
		end
		check({31'h0, rd[7]}, 32'h1);
	endtask
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails = fails + 1;
			report_and_stop();
		end
	end
	// ====================
	// main sequence
	initial begin
		logic [7:0] acc;
		logic [7:0] tbl [5];
		tbl = '{8'h10, 8'h00, 8'h20, 8'h08, 8'h02};
		acc = 8'h81;
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'h0;
		@(posedge core_clk);
		apb(1'h0, CTRL_OFS, 32'h0);
		check(rd, 32'h0);
		apb(1'h0, STAT_OFS, 32'h0);
		check(rd, 32'h0);
		apb(1'h0, 8'h18, 32'h0);
		check(rd, 32'h0);
		check({31'h0, err}, 32'h1);
		fread(21'h123);
		check(rd, {16'h0, 16'h0123 ^ 16'hA5C3});
		cmd(21'h0, 16'hAB70);
		fread(21'h0);
		check(rd, 32'h81);
		apb(1'h0, STAT_OFS, 32'h0);
		check(rd, 32'h8002);
		fread(21'h7);
		check(rd, 32'h81);
		for (int i = 0; i < 5; i++) begin
			run_op(i[0] ? 16'h0020 : 16'h0040, tbl[i]);
			acc = acc | tbl[i];
			check(rd, {24'h0, acc});
		end
		apb(1'h0, STAT_OFS, 32'h0);
		check(rd, 32'hBA0A);
		apb(1'h1, CTRL_OFS, 32'h1);
		run_op(16'h0040, 8'h00);
		check(rd, 32'h81);
		apb(1'h1, CTRL_OFS, 32'h0);
		run_op(16'h0040, 8'h08);
		check(rd, 32'h89);
		run_op(16'h0020, 8'h00);
		check(rd, 32'h89);
		cmd(21'h0, 16'h0050);
		cmd(21'h0, 16'h0070);
		fread(21'h0);
		check(rd, 32'h81);
		cmd(21'h0, 16'h00FF);
		// freeze mid-read, then a refused go while still busy
		apb(1'h1, ADDR_OFS, 32'h55);
		apb(1'h1, GO_OFS, 32'h2);
		clk_en <= 1'h0;
		repeat (10) @(posedge core_clk);
		check({31'h0, ce_n}, 32'h0);
		clk_en <= 1'h1;
		apb(1'h1, GO_OFS, 32'h1);
		check({31'h0, err}, 32'h1);
		idle();
		apb(1'h0, RDATA_OFS, 32'h0);
		check(rd, {16'h0, 16'h0055 ^ 16'hA5C3});
		run_op(16'h0020, 8'h20);
		check(rd, 32'hA1);
		apb(1'h1, GO_OFS, 32'h4);
		idle();
		apb(1'h0, STAT_OFS, 32'h0);
		check(rd, 32'h0);
		cmd(21'h0, 16'h0070);
		fread(21'h0);
		check(rd, 32'h81);
		report_and_stop();
	end
endmodule
